// ==== logic/bus_term_device.sv ====
// Notes on behaviour
// - Fault with halt starts retry, no trap
// - Retry waits on halt, repeats same cycle
// - System drops fault before halt on retry
// - Locked read-modify-write cycles never retry
// - External halt stops device while held
// - Arbitration continues; fault under halt retries
// - Reset instruction under halt resets core
// - Single-step: one cycle per halt release
// - Fault during fault handling: halt, drive halt
// - Faults on retries never double fault
// - Fault during vector fetch is double fault
// - Reset loads stack, pc, level seven
// - Reset instruction drives reset 124 clocks
// - System holds reset 132, or 10 with halt
// - System changes inputs on rising edges only
// - Acknowledge alone ends cycle normally
// - Halt with acknowledge: end, then stop
// - Fault without halt ends cycle, trap
// - Fault with halt ends cycle, rerun later
// - Halt released before fault: illegal, vector 0
// - Lingering fault ends next cycle as fault
// - System drops acknowledge, fault with strobe
// - Bus inputs synchronised before use
// - Fault ends with acknowledge S7, alone S9
`default_nettype none
module bus_term_device
  import bus_term_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Bus side
  bus_term_if.device       bus,
  // Core side requests
  input  wire logic        i_cycle_req,     // Start a bus cycle
  input  wire logic        i_cycle_rmw,     // Cycle is read-modify-write
  input  wire logic [23:0] i_cycle_addr,
  input  wire logic [2:0]  i_cycle_fc,
  input  wire logic [15:0] i_cycle_wdata,
  input  wire logic        i_cycle_write,
  input  wire logic        i_reset_instr,   // Pulse: execute reset instruction
  input  wire logic        i_instr_start,   // Pulse: a new instruction begins
  input  wire logic        i_bus_grant,     // Arbitration grant held for another master
  // Core side results
  output logic             o_cycle_done,    // Pulse with o_end_code
  output end_code_t        o_end_code,
  output logic [7:0]       o_trap_vector,
  output logic             o_halted,
  output logic             o_double_fault,
  output logic             o_core_reset,    // Core reset request level
  output logic [23:0]      o_cur_addr,
  output logic [2:0]       o_cur_fc,
  output logic [15:0]      o_cur_wdata,
  output logic [23:0]      o_fetch_addr,    // Vector fetch address after reset
  output logic [2:0]       o_int_level
);
  typedef enum logic [3:0] {
    ST_RESET_VEC0, ST_RESET_GAP, ST_RESET_VEC1, ST_IDLE, ST_CYCLE, ST_FAULT_WAIT,
    ST_RETRY_WAIT, ST_HALT_WAIT, ST_STOPPED, ST_DEAD
  } state_t;

  state_t            state_q, state_d;
  logic [3:0]        sync_in;
  logic              ack_s, fault_s, halt_s, rst_s;
  logic              in_exc_q, retrying_q, rmw_q, write_q;
  logic [CNT_W-1:0]  rst_cnt_q, hold_cnt_q;
  logic              rst_drive_q;

  // Pins are asynchronous to the core clock
  sync2 #(.W(4)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({bus.transfer_acknowledge, bus.bus_fault_input, bus.halt_in, bus.reset_in}),
    .o_sync     (sync_in)
  );
  assign {ack_s, fault_s, halt_s, rst_s} = sync_in;

  // Termination decode; fault outranks acknowledge, halt picks retry
  wire fault_term  = fault_s;
  wire retry_term  = fault_s && halt_s && !rmw_q;
  wire double_hit  = fault_s && !halt_s && in_exc_q && !retrying_q;
  wire halt_hold   = halt_s && !bus.halt_out_en;
  wire ext_rst_len = (hold_cnt_q >= CNT_W'(RESET_ALONE_CYCLES))
                  || (halt_s && hold_cnt_q >= CNT_W'(RESET_HALT_CYCLES));
  // Own reset instruction masks a short external reset; under halt it resets the core
  wire core_rst    = (rst_s && (!rst_drive_q || ext_rst_len || halt_s))
                  || (rst_drive_q && halt_s);
  // A lingering acknowledge would end a fresh cycle at once
  wire start_cyc   = i_cycle_req && !halt_s && !i_bus_grant && !ack_s;

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET_VEC0: if (fault_s) state_d = ST_DEAD;
                     else if (ack_s) state_d = ST_RESET_GAP;
      // Strobe drops between fetches so each fetch has its own answer
      ST_RESET_GAP:  if (!ack_s) state_d = ST_RESET_VEC1;
      ST_RESET_VEC1: if (fault_s) state_d = ST_DEAD;
                     else if (ack_s) state_d = ST_IDLE;
      ST_IDLE:       if (start_cyc) state_d = ST_CYCLE;
      ST_CYCLE: begin
        if (double_hit) state_d = ST_DEAD;
        else if (retry_term) state_d = ST_RETRY_WAIT;
        else if (fault_term) state_d = ST_FAULT_WAIT;
        else if (ack_s && halt_s) state_d = ST_HALT_WAIT;
        else if (ack_s) state_d = ST_IDLE;
      end
      ST_FAULT_WAIT: if (!fault_s) state_d = ST_IDLE;
      ST_RETRY_WAIT: if (!halt_s) state_d = fault_s ? ST_IDLE : ST_CYCLE;
      ST_HALT_WAIT:  if (!halt_s) state_d = ST_IDLE;
      default:       state_d = state_q;                         // Only reset leaves
    endcase
  end

  wire end_ev = (state_q == ST_CYCLE) && (state_d != ST_CYCLE);
  wire illegal_ev = (state_q == ST_RETRY_WAIT) && !halt_s && fault_s;

  // State and context registers; core reset restarts the vector fetch
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q    <= ST_RESET_VEC0;
      in_exc_q   <= 1'b0;
      retrying_q <= 1'b0;
      rmw_q      <= 1'b0;
      write_q    <= 1'b0;
      o_cur_addr <= 24'h000000;
      o_cur_fc   <= 3'h0;
      o_cur_wdata <= 16'h0000;
    end else if (core_rst) begin
      state_q    <= ST_RESET_VEC0;
      in_exc_q   <= 1'b0;
      retrying_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // Latch only at a fresh start so a retry repeats the same cycle
      if (state_q == ST_IDLE && start_cyc) begin
        o_cur_addr  <= i_cycle_addr;
        o_cur_fc    <= i_cycle_fc;
        o_cur_wdata <= i_cycle_wdata;
        rmw_q       <= i_cycle_rmw;
        write_q     <= i_cycle_write;
        retrying_q  <= 1'b0;
      end else if (state_d == ST_RETRY_WAIT) begin
        retrying_q <= 1'b1;
      end
      if ((end_ev && state_d == ST_FAULT_WAIT) || illegal_ev) in_exc_q <= 1'b1;
      else if (i_instr_start) in_exc_q <= 1'b0;
    end
  end

  // Result reporting
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cycle_done   <= 1'b0;
      o_end_code     <= END_NONE;
      o_trap_vector  <= 8'h00;
      o_halted       <= 1'b0;
      o_double_fault <= 1'b0;
      o_core_reset   <= 1'b0;
      o_int_level    <= RESET_INT_LEVEL;
      o_fetch_addr   <= VEC_STACK_ADDR;
    end else begin
      o_cycle_done   <= end_ev || illegal_ev;
      o_core_reset   <= core_rst;
      o_halted       <= state_q inside {ST_HALT_WAIT, ST_RETRY_WAIT, ST_DEAD} || halt_s;
      o_double_fault <= (state_d == ST_DEAD) && !core_rst;
      o_fetch_addr   <= (state_d == ST_RESET_VEC1) ? VEC_PC_ADDR : VEC_STACK_ADDR;
      if (core_rst) o_int_level <= RESET_INT_LEVEL;
      if (illegal_ev) begin
        o_end_code    <= END_ILLEGAL;
        o_trap_vector <= ILLEGAL_VECTOR;
      end else if (end_ev) begin
        o_end_code    <= state_d == ST_RETRY_WAIT ? END_RETRY :
                         state_d == ST_FAULT_WAIT || state_d == ST_DEAD ? END_FAULT :
                         state_d == ST_HALT_WAIT ? END_HALT : END_NORMAL;
        o_trap_vector <= BUS_FAULT_VECTOR;
      end
    end
  end

  // Reset output pulse and external reset length count
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt_q   <= '0;
      rst_drive_q <= 1'b0;
      hold_cnt_q  <= '0;
    end else begin
      if (i_reset_instr && !rst_drive_q) begin
        rst_drive_q <= 1'b1;
        rst_cnt_q   <= CNT_W'(RESET_OUT_CYCLES - 1);
      end else if (rst_drive_q) begin
        if (rst_cnt_q == '0) rst_drive_q <= 1'b0;
        else rst_cnt_q <= rst_cnt_q - 1'b1;
      end
      if (!rst_s) hold_cnt_q <= '0;
      else if (hold_cnt_q != '1) hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  // Bus pin drive; strobe falls with the cycle so inputs clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.address_strobe <= 1'b0;
      bus.halt_out       <= 1'b0;
      bus.halt_out_en    <= 1'b0;
      bus.reset_out      <= 1'b0;
      bus.reset_out_en   <= 1'b0;
    end else begin
      bus.address_strobe <= state_d inside {ST_CYCLE, ST_RESET_VEC0, ST_RESET_VEC1}
                            && !core_rst;
      bus.halt_out       <= state_d == ST_DEAD && !core_rst;
      bus.halt_out_en    <= state_d == ST_DEAD && !core_rst;
      bus.reset_out      <= rst_drive_q;
      bus.reset_out_en   <= rst_drive_q;
    end
  end

  wire unused_ok = write_q ^ halt_hold;
endmodule
`default_nettype wire

// ==== logic/bus_term_if.sv ====
`default_nettype none
interface bus_term_if;
  // Active-low wires of the bus, modelled as assert-high levels here
  logic address_strobe;
  logic transfer_acknowledge;
  logic bus_fault_input;
  logic halt_in;       // Halt driven by the system side
  logic halt_out;      // Halt driven by the device on a double fault
  logic halt_out_en;
  logic reset_in;      // Reset driven by the system side
  logic reset_out;     // Reset driven by the reset instruction
  logic reset_out_en;
  modport device (
    output address_strobe, halt_out, halt_out_en, reset_out, reset_out_en,
    input  transfer_acknowledge, bus_fault_input, halt_in, reset_in
  );
  modport system (
    input  address_strobe, halt_out, halt_out_en, reset_out, reset_out_en,
    output transfer_acknowledge, bus_fault_input, halt_in, reset_in
  );
endinterface
`default_nettype wire

// ==== logic/bus_term_pkg.sv ====
`default_nettype none
package bus_term_pkg;
  // Reset pulse driven by the reset instruction, in clock periods
  localparam int unsigned       RESET_OUT_CYCLES     = 124;
  // Least external reset hold for a core reset, alone or with halt
  localparam int unsigned       RESET_ALONE_CYCLES   = 132;
  localparam int unsigned       RESET_HALT_CYCLES    = 10;
  localparam int unsigned       CNT_W                = 8;
  // Vector table locations and reset interrupt level
  localparam logic [23:0]       VEC_STACK_ADDR       = 24'h000000;
  localparam logic [23:0]       VEC_PC_ADDR          = 24'h000004;
  localparam logic [2:0]        RESET_INT_LEVEL      = 3'h7;
  localparam logic [7:0]        ILLEGAL_VECTOR       = 8'h00;
  localparam logic [7:0]        BUS_FAULT_VECTOR     = 8'h02;
  // Cycle end codes reported to the user side
  typedef enum logic [2:0] {
    END_NONE, END_NORMAL, END_HALT, END_FAULT, END_RETRY, END_ILLEGAL
  } end_code_t;
endpackage
`default_nettype wire

// ==== logic/bus_term_system.sv ====
`default_nettype none
// Far end: a slave that acknowledges, faults or asks for retries
module bus_term_system
  import bus_term_pkg::*;
(
  // Clock and reset
  input  wire logic  i_core_clk,
  input  wire logic  i_rst,
  // Bus side
  bus_term_if.system bus,
  // User side controls, levels except the reset pulse
  input  wire logic  i_do_fault,     // Answer the next cycle with fault
  input  wire logic  i_do_retry,     // Answer with fault plus halt
  input  wire logic  i_hold_halt,    // Hold halt (stop, single-step)
  input  wire logic  i_do_reset,     // Pulse: drive a core reset
  output logic       o_dev_halting,  // Device drives halt
  output logic       o_dev_reset     // Device drives reset
);
  typedef enum logic [1:0] {S_IDLE, S_ANSWER, S_RELEASE} sys_state_t;
  sys_state_t       st_q;
  logic [1:0]       as_sync;
  logic             retry_q, rel_q;
  logic [CNT_W-1:0] rcnt_q;

  sync2 #(.W(2)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({bus.address_strobe, bus.halt_out_en & bus.halt_out}),
    .o_sync     (as_sync)
  );

  // Outputs change on rising edges only
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= S_IDLE;
      bus.transfer_acknowledge <= 1'b0;
      bus.bus_fault_input <= 1'b0;
      bus.halt_in <= 1'b0;
      retry_q <= 1'b0;
      rel_q <= 1'b0;
      o_dev_halting <= 1'b0;
      o_dev_reset <= 1'b0;
    end else begin
      o_dev_halting <= as_sync[0];
      o_dev_reset <= bus.reset_out_en & bus.reset_out;
      case (st_q)
        S_IDLE: if (as_sync[1]) begin
          st_q <= S_ANSWER;
          retry_q <= i_do_retry;
          bus.bus_fault_input <= i_do_fault | i_do_retry;
          bus.transfer_acknowledge <= !(i_do_fault | i_do_retry);
          bus.halt_in <= i_do_retry | i_hold_halt;
        end else begin
          bus.halt_in <= i_hold_halt;
        end
        S_ANSWER: if (!as_sync[1]) begin
          bus.transfer_acknowledge <= 1'b0;
          bus.bus_fault_input <= 1'b0;
          st_q <= retry_q ? S_RELEASE : S_IDLE;
          rel_q <= 1'b0;
        end
        default: begin
          rel_q <= 1'b1;                                       // Fault already low
          if (rel_q) begin
            bus.halt_in <= i_hold_halt;
            st_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Core reset held beyond the reset instruction length
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rcnt_q <= '0;
      bus.reset_in <= 1'b0;
    end else begin
      if (i_do_reset) rcnt_q <= CNT_W'(RESET_ALONE_CYCLES + 4);
      else if (rcnt_q != '0) rcnt_q <= rcnt_q - 1'b1;
      bus.reset_in <= (rcnt_q != '0) || i_do_reset;
    end
  end
endmodule
`default_nettype wire

// ==== logic/sync2.sv ====
`default_nettype none
// Two-stage synchroniser for a group of pin levels
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== verification/bus_term_assertions.sv ====
`default_nettype none
// Bus-side checks between the device end and the system end
module bus_term_assertions
  import bus_term_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Interface wires
  input wire logic address_strobe,
  input wire logic transfer_acknowledge,
  input wire logic bus_fault_input,
  input wire logic halt_in,
  input wire logic halt_out,
  input wire logic halt_out_en,
  input wire logic reset_in,
  input wire logic reset_out,
  input wire logic reset_out_en
);
  logic [7:0] pulse_len_q;
  logic       retry_pend_q;
  logic       retry_set;

  // A retried cycle stays owed until its strobe rises again
  assign retry_set = address_strobe & bus_fault_input & halt_in;

  // Pulse length counter; a counter avoids a long repetition
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_len_q  <= 8'h00;
      retry_pend_q <= 1'b0;
    end else begin
      pulse_len_q  <= reset_out_en ? pulse_len_q + 8'h01 : 8'h00;
      retry_pend_q <= (retry_pend_q & ~address_strobe) | retry_set;
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_ack_ends_cycle: assert property (
    $rose(transfer_acknowledge) && address_strobe && !bus_fault_input
    |-> address_strobe[*2] ##[1:6] !address_strobe) else $error("ack did not end cycle");
  a_fault_ends_cycle: assert property (
    $rose(bus_fault_input) && address_strobe |-> address_strobe[*2] ##[1:6] !address_strobe)
    else $error("fault did not end cycle");
  a_lingering_fault: assert property (
    $rose(address_strobe) && bus_fault_input |-> ##[1:8] !address_strobe)
    else $error("cycle under held fault not ended");
  a_retry_ends: assert property (
    retry_set |-> ##[1:6] !address_strobe) else $error("retry did not end cycle");
  a_rerun_after_halt: assert property (
    $fell(halt_in) && retry_pend_q && !bus_fault_input && !$past(bus_fault_input)
    |-> ##[1:8] address_strobe) else $error("no rerun after halt release");
  a_halt_keeps_idle: assert property (
    halt_in[*4] ##0 !address_strobe |=> !address_strobe) else $error("cycle began under halt");
  a_reset_pulse_len: assert property (
    $fell(reset_out_en) |-> pulse_len_q == RESET_OUT_CYCLES[7:0])
    else $error("reset pulse length wrong");
  a_reset_out_level: assert property (
    reset_out_en |-> reset_out) else $error("reset enabled but not driven");
  a_dfault_latched: assert property (
    halt_out_en && !reset_in && !$past(reset_in) && !$past(reset_in, 2) && !$past(reset_in, 3)
    |=> halt_out_en) else $error("double fault halt released without reset");
  a_dfault_stopped: assert property (
    $past(halt_out_en) && halt_out_en |-> halt_out && !address_strobe)
    else $error("double fault not holding halt");
endmodule
`default_nettype wire

// ==== verification/test_bus_termination_halt_reset_control.sv ====
`default_nettype none
module test_bus_termination_halt_reset_control;
  import bus_term_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {end_code_t code; logic [23:0] addr; logic any;} exp_t;
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        req, rmw, wr, rst_ins, ins_st, grant, do_fault, do_retry, hold_halt, do_reset;
  logic [23:0] addr, cur_addr, fetch_addr;
  logic [2:0]  fc, int_level, cur_fc;
  logic [15:0] wdata, cur_wdata;
  logic [7:0]  trap_vec;
  logic        done, halted, dfault, core_rst, dev_halting, dev_reset;
  end_code_t   end_code;
  int          failures, num_checks, cycles, n;
  bit          watch;
  exp_t        expq[$];
  exp_t        exp_now;

  always #4 i_core_clk = ~i_core_clk;
  bus_term_if bus ();
  bus_term_device u_bus_term_device (.i_core_clk(i_core_clk), .i_rst(i_rst), .bus(bus.device),
    .i_cycle_req(req), .i_cycle_rmw(rmw), .i_cycle_addr(addr), .i_cycle_fc(fc),
    .i_cycle_wdata(wdata), .i_cycle_write(wr), .i_reset_instr(rst_ins), .i_instr_start(ins_st),
    .i_bus_grant(grant), .o_cycle_done(done), .o_end_code(end_code), .o_trap_vector(trap_vec),
    .o_halted(halted), .o_double_fault(dfault), .o_core_reset(core_rst), .o_cur_addr(cur_addr),
    .o_cur_fc(cur_fc), .o_cur_wdata(cur_wdata),
    .o_fetch_addr(fetch_addr), .o_int_level(int_level));
  bus_term_system u_bus_term_system (.i_core_clk(i_core_clk), .i_rst(i_rst), .bus(bus.system),
    .i_do_fault(do_fault), .i_do_retry(do_retry), .i_hold_halt(hold_halt),
    .i_do_reset(do_reset), .o_dev_halting(dev_halting), .o_dev_reset(dev_reset));
  bus_term_assertions u_bus_term_assertions (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .address_strobe(bus.address_strobe), .transfer_acknowledge(bus.transfer_acknowledge),
    .bus_fault_input(bus.bus_fault_input), .halt_in(bus.halt_in), .halt_out(bus.halt_out),
    .halt_out_en(bus.halt_out_en), .reset_in(bus.reset_in), .reset_out(bus.reset_out),
    .reset_out_en(bus.reset_out_en));

  task automatic chk_vec(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Bounded wait on one of a few levels, at falling edges
  function automatic logic sel(input int s);
    case (s)
      0: return bus.address_strobe;
      1: return !bus.address_strobe;
      2: return dfault;
      3: return core_rst;
      4: return dev_reset;
      default: return halted;
    endcase
  endfunction
  task automatic wt(input int s, input int lim);
    n = 0;
    while (sel(s) !== 1'b1 && n < lim) begin
      @(negedge i_core_clk);
      n++;
    end
    chk_vec("wait_level", 24'(s), n < lim ? 24'(s) : 24'hFFFFFF);
  endtask
  task automatic drain(input int k);
    n = 0;
    while (expq.size() > k && n < 400) begin
      @(negedge i_core_clk);
      n++;
    end
    chk_vec("pending_ends", 24'(k), 24'(expq.size()));
  endtask
  // Request raised once the last strobe is down, held until the strobe shows it was taken
  task automatic cyc(input end_code_t c, input logic [23:0] a, input logic m, input logic any);
    expq.push_back('{c, a, any});
    wt(1, 100);
    @(negedge i_core_clk);
    {addr, rmw, fc, wdata, wr, req} = {a, m, 3'($urandom), 16'($urandom), 1'($urandom), 1'b1};
    wt(0, 100);
    req = 1'b0;
  endtask
  task automatic boot();
    {i_rst, watch, do_fault, do_retry, hold_halt} = 5'h10;
    repeat (10) @(negedge i_core_clk);
    i_rst = 1'b0;
    wt(0, 20);
    chk_vec("fetch_addr", VEC_STACK_ADDR, fetch_addr);
    chk_vec("int_level", 24'(RESET_INT_LEVEL), 24'(int_level));
    wt(1, 50);
    wt(0, 50);
    chk_vec("fetch_addr", VEC_PC_ADDR, fetch_addr);
    wt(1, 50);
    watch = 1'b1;
  endtask

  // Every reported cycle end is matched against the oldest note
  always @(negedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end else if (watch && done === 1'b1) begin
      if (expq.size() == 0) begin
        chk_vec("spare_end", 24'h0, 24'h1);
      end else begin
        exp_now = expq.pop_front();
        if (!exp_now.any) chk_vec("end_code", 24'(exp_now.code), 24'(end_code));
        if (exp_now.code == END_FAULT)
          chk_vec("trap_vec", 24'(BUS_FAULT_VECTOR), 24'(trap_vec));
        chk_vec("cycle_addr", exp_now.addr, cur_addr);
        chk_vec("cycle_fc", 24'(fc), 24'(cur_fc));
        chk_vec("cycle_wdata", 24'(wdata), 24'(cur_wdata));
      end
    end
  end

  initial begin
    {req, rmw, wr, rst_ins, ins_st, grant, do_fault, do_retry, hold_halt, do_reset} = '0;
    {addr, fc, wdata, failures, num_checks, cycles} = '0;
    void'($urandom(32'h2DAC));
    boot();
    for (int i = 0; i < 4; i++) cyc(END_NORMAL, 24'($urandom), 1'b0, 1'b0);
    drain(0);
    $display("test normal finished");
    // Fault, then a second fault before any instruction starts
    do_fault = 1'b1;
    cyc(END_FAULT, 24'h000100, 1'b0, 1'b0);
    drain(0);
    // A new instruction closes the exception, so the next fault is single
    @(negedge i_core_clk) ins_st = 1'b1;
    @(negedge i_core_clk) ins_st = 1'b0;
    cyc(END_FAULT, 24'h000101, 1'b0, 1'b0);
    drain(0);
    chk_vec("no_dfault", 24'h0, 24'(dfault));
    cyc(END_FAULT, 24'h000102, 1'b0, 1'b0);
    drain(0);
    wt(2, 20);
    // The system end sees halt only after its synchroniser
    repeat (4) @(negedge i_core_clk);
    chk_vec("dev_halting", 24'h1, 24'(dev_halting));
    do_fault = 1'b0;
    @(negedge i_core_clk) do_reset = 1'b1;
    @(negedge i_core_clk) do_reset = 1'b0;
    wt(3, 300);
    boot();
    $display("test double_fault finished");
    // Retry reruns the same address once halt drops
    do_retry = 1'b1;
    expq.push_back('{END_RETRY, 24'h000200, 1'b0});
    cyc(END_NORMAL, 24'h000200, 1'b0, 1'b0);
    drain(1);
    do_retry = 1'b0;
    drain(0);
    // Locked cycle traps even with halt, then reset instruction under halt
    do_retry = 1'b1;
    cyc(END_FAULT, 24'h000300, 1'b1, 1'b0);
    drain(0);
    {hold_halt, do_retry} = 2'b10;
    @(negedge i_core_clk) rst_ins = 1'b1;
    @(negedge i_core_clk) rst_ins = 1'b0;
    wt(3, 300);
    boot();
    $display("test retry finished");
    // Halt holds off a request, then one step at a time
    hold_halt = 1'b1;
    // Halt must reach the device before the request shows
    repeat (8) @(negedge i_core_clk);
    expq.push_back('{END_HALT, 24'h000400, 1'b0});
    {addr, rmw, req} = {24'h000400, 2'b01};
    repeat (12) @(negedge i_core_clk) chk_vec("strobe_halted", 24'h0, 24'(bus.address_strobe));
    hold_halt = 1'b0;
    wt(0, 20);
    {req, hold_halt} = 2'b01;
    drain(0);
    wt(5, 20);
    hold_halt = 1'b0;
    // Halt must clear in the device, or the next pulse resets the core
    repeat (8) @(negedge i_core_clk);
    $display("test single_step finished");
    // Reset instruction pulse, core left running
    @(negedge i_core_clk) rst_ins = 1'b1;
    @(negedge i_core_clk) rst_ins = 1'b0;
    wt(4, 50);
    n = 0;
    while (dev_reset === 1'b1 && n < 300) begin
      @(negedge i_core_clk);
      n++;
    end
    chk_vec("reset_len", 24'(RESET_OUT_CYCLES), 24'(n));
    chk_vec("core_reset", 24'h0, 24'(core_rst));
    $display("test reset_pulse finished");
    complete_run();
  end
endmodule
`default_nettype wire
